/* File: core/vdc_pkg.sv */
// Operation
// - Output equals VCO over total divide
// - VCO equals crystal times feedback divider
// - Feedback divider is unsigned 11.32 fixed point
// - Host keeps feedback divider in range
// - High-speed divider 11 bits, 4 to 2046
// - Odd ratios 4-33 only when low-speed is one
// - Low-speed two or more: any ratio 4-2046
// - Low-speed divides by two to exponent
// - Exponents 5, 6, 7 divide by 32
// - Feedback scaled by voltage offset times gain
// - Above half supply raises, below lowers frequency
// - Host keeps VCO within grade limits
// - Host keeps output within grade range
// - All divider fields are unsigned
// - Dividers loaded only over serial registers
// - Host recomputes gain calibration after change
// - Calibration uses predivider by feedback integer
package vdc_pkg;

    // ==========================================
    // Field widths
    localparam int FB_W = 43;
    localparam int FB_FRAC_W = 32;
    localparam int FB_INT_W = 11;
    localparam int HS_W = 11;
    localparam int LS_W = 3;
    localparam int GAIN_W = 16;
    localparam int CV_W = 12;
    localparam int RATIO_W = 32;
    localparam int DIV_W = 64;
    localparam int N_W = 16;

    // ==========================================
    // Divider limits
    localparam logic [HS_W-1:0] HS_MIN = 11'h004;
    localparam logic [HS_W-1:0] HS_MAX = 11'h7FE;
    localparam logic [HS_W-1:0] HS_ODD_MAX = 11'h021;
    localparam logic [LS_W-1:0] LS_EXP_MAX = 3'h5;
    localparam logic [FB_W-1:0] FB_MIN = 43'h003C0000000 << 4;
    localparam logic [FB_W-1:0] FB_MAX = 43'h7FDFFFFFFFF;

    // ==========================================
    // Frequencies in Hz (grade A limits)
    localparam logic [47:0] XTAL_HZ = 48'h0000_0918_7DC0;
    localparam logic [47:0] VCO_MIN_HZ = 48'h0002_83BA_EC00;
    localparam logic [47:0] VCO_MAX_HZ = 48'h0003_0E25_37C6;
    localparam logic [47:0] FOUT_MIN_HZ = 48'h0000_0003_0D40;
    localparam logic [47:0] FOUT_MAX_HZ = 48'h0000_B2D0_5E00;

    // ==========================================
    // Gain calibration constants
    localparam logic [23:0] CAL_SCALE = 24'h0C_8000;
    localparam logic [11:0] CAL_XTAL = 12'h5F6;
    localparam logic [10:0] PRE_EDGE_1 = 11'h048;
    localparam logic [10:0] PRE_EDGE_2 = 11'h04F;
    localparam logic [10:0] PRE_EDGE_3 = 11'h056;
    localparam logic [4:0] PRE_0 = 5'h10;
    localparam logic [4:0] PRE_1 = 5'h12;
    localparam logic [4:0] PRE_2 = 5'h14;
    localparam logic [4:0] PRE_3 = 5'h16;

    // ==========================================
    // Device register byte addresses and resets
    localparam logic [7:0] DEV_FB_0 = 8'h00;
    localparam logic [7:0] DEV_HS_LO = 8'h06;
    localparam logic [7:0] DEV_HS_HI = 8'h07;
    localparam logic [7:0] DEV_LS = 8'h08;
    localparam logic [7:0] DEV_GAIN_LO = 8'h09;
    localparam logic [7:0] DEV_GAIN_HI = 8'h0A;
    localparam logic [7:0] DEV_LAST = 8'h0A;
    localparam logic [FB_W-1:0] FB_RESET = 43'h04700000000;
    localparam logic [HS_W-1:0] HS_RESET = 11'h046;
    localparam logic [LS_W-1:0] LS_RESET = 3'h0;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 16'h0000;
    localparam logic [CV_W:0] CV_MID = 13'h0800;
    localparam int PULL_SHIFT = 32;
    localparam logic [RATIO_W-1:0] RATIO_MAX = 32'h8000_0000;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [6:0] DIV_STEPS = 7'h40;

    // ==========================================
    // Host Wishbone register byte offsets
    localparam logic [7:0] HR_FB_FRAC = 8'h00;
    localparam logic [7:0] HR_FB_INT = 8'h04;
    localparam logic [7:0] HR_HS = 8'h08;
    localparam logic [7:0] HR_LS = 8'h0C;
    localparam logic [7:0] HR_GAIN = 8'h10;
    localparam logic [7:0] HR_CTRL = 8'h14;
    localparam logic [7:0] HR_STATUS = 8'h18;
    localparam logic [7:0] HR_CAL = 8'h1C;

    // Two to the saturated low-speed exponent times high-speed ratio
    function automatic logic [N_W-1:0] total_div(input logic [HS_W-1:0] hs, input logic [LS_W-1:0] ls);
        logic [LS_W-1:0] e;
        e = (ls > LS_EXP_MAX) ? LS_EXP_MAX : ls;
        return N_W'({5'h00, hs} << e);
    endfunction : total_div

endpackage : vdc_pkg

/* File: core/vdc_link_if.sv */
`timescale 1ns/10ps
// ==========================================
// Serial register link, one byte write per frame
interface vdc_link_if;
    logic ser_frame; // High around 16 bits
    logic ser_valid; // One bit per clock while high
    logic ser_bit; // Address then data, MSB first

    modport host (output ser_frame, output ser_valid, output ser_bit);
    modport device (input ser_frame, input ser_valid, input ser_bit);
endinterface : vdc_link_if

/* File: core/vdc_udiv.sv */
`timescale 1ns/10ps
// ==========================================
// Restoring unsigned divider, one bit per clock
module vdc_udiv
    import vdc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [DIV_W-1:0] num,
    input wire logic [DIV_W-1:0] den,
    output logic busy,
    output logic done,
    output logic [DIV_W-1:0] quo
);
    logic [DIV_W-1:0] rem;
    logic [DIV_W-1:0] dvs;
    logic [6:0] count;
    logic [DIV_W+1:0] trial;

    // Trial subtraction of shifted remainder
    assign trial = {1'b0, rem, quo[DIV_W-1]} - {2'b00, dvs};

    // Iteration
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rem <= '0;
            dvs <= '0;
            quo <= '0;
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                rem <= '0;
                dvs <= den;
                quo <= num;
                count <= DIV_STEPS;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                rem <= trial[DIV_W+1] ? {rem[DIV_W-2:0], quo[DIV_W-1]} : trial[DIV_W-1:0];
                quo <= {quo[DIV_W-2:0], ~trial[DIV_W+1]};
                count <= count - 7'h01;
                if (count == 7'h01)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

endmodule : vdc_udiv

/* File: core/vdc_device.sv */
`timescale 1ns/10ps
// ==========================================
// Oscillator divider chain: serial registers, pull, NCO
module vdc_device
    import vdc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_B,
    vdc_link_if.device LINK,
    input wire logic [CV_W-1:0] CONTROL_VOLTAGE_PIN,
    output logic OUTPUT_CLOCK,
    output logic [RATIO_W-1:0] OUTPUT_RATIO
);
    // ==========================================
    // Declarations
    logic [FB_W-1:0] feedback_divider;
    logic [HS_W-1:0] high_speed_divider;
    logic [LS_W-1:0] low_speed_divider;
    logic [GAIN_W-1:0] pull_gain;
    logic [15:0] shift;
    logic [4:0] nbits;
    logic frame_d;
    logic commit;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [HS_W-1:0] hs_used;
    logic [N_W-1:0] n_total;
    logic signed [CV_W:0] cv_off;
    logic signed [73:0] pull_prod;
    logic signed [74:0] fb_sum;
    logic [FB_W:0] fb_eff;
    logic div_start;
    logic div_busy;
    logic div_done;
    logic [DIV_W-1:0] div_quo;
    logic [RATIO_W-1:0] phase;
    logic [RATIO_W-1:0] next_phase;

    // ==========================================
    // Serial link receiver
    assign commit = frame_d && !LINK.ser_frame && (nbits == FRAME_BITS);
    assign wr_addr = shift[15:8];
    assign wr_data = shift[7:0];

    // Bit collection per frame
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            shift <= '0;
            nbits <= '0;
            frame_d <= 1'b0;
        end
        else
        begin
            frame_d <= LINK.ser_frame;
            if (!LINK.ser_frame)
            begin
                nbits <= '0;
            end
            else if (LINK.ser_valid)
            begin
                shift <= {shift[14:0], LINK.ser_bit};
                if (nbits <= FRAME_BITS)
                begin
                    nbits <= nbits + 5'h01; // Over-long frame never commits
                end
            end
        end
    end

    // ==========================================
    // Register file, written only by link frames
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            feedback_divider <= FB_RESET;
            high_speed_divider <= HS_RESET;
            low_speed_divider <= LS_RESET;
            pull_gain <= GAIN_RESET;
        end
        else if (commit)
        begin
            case (wr_addr)
                DEV_HS_LO: high_speed_divider[7:0] <= wr_data;
                DEV_HS_HI: high_speed_divider[10:8] <= wr_data[2:0];
                DEV_LS: low_speed_divider <= wr_data[2:0];
                DEV_GAIN_LO: pull_gain[7:0] <= wr_data;
                DEV_GAIN_HI: pull_gain[15:8] <= wr_data;
                default:
                begin
                    // Six bytes of the 11.32 feedback value
                    if (wr_addr < DEV_HS_LO)
                    begin
                        feedback_divider <= fb_byte(feedback_divider, wr_addr[2:0], wr_data);
                    end
                end
            endcase
        end
    end

    // Byte lane merge into the feedback register
    function automatic logic [FB_W-1:0] fb_byte(input logic [FB_W-1:0] old, input logic [2:0] idx,
        input logic [7:0] data);
        logic [47:0] w;
        w = {5'h00, old};
        w[idx*8 +: 8] = data;
        return w[FB_W-1:0];
    endfunction : fb_byte

    // ==========================================
    // High-speed ratio legalised
    always_comb
    begin
        hs_used = high_speed_divider;
        if (hs_used < HS_MIN)
        begin
            hs_used = HS_MIN;
        end
        else if (hs_used > HS_MAX)
        begin
            hs_used = HS_MAX;
        end
        // Odd ratios above 33 only with low-speed above one
        if (low_speed_divider == 3'h0 && hs_used > HS_ODD_MAX && hs_used[0])
        begin
            hs_used = {hs_used[HS_W-1:1], 1'b0};
        end
    end

    // Total output divide; any ratio once low-speed is two or more
    assign n_total = total_div(hs_used, low_speed_divider);

    // ==========================================
    // Control voltage pull of the feedback value
    assign cv_off = $signed({1'b0, CONTROL_VOLTAGE_PIN}) - $signed(CV_MID);
    assign pull_prod = $signed({1'b0, feedback_divider}) * cv_off * $signed({1'b0, pull_gain});

    // Effective feedback, floored at zero
    always_comb
    begin
        fb_sum = $signed({32'h0, feedback_divider}) + (pull_prod >>> PULL_SHIFT);
        if (fb_sum < 0)
        begin
            fb_eff = '0;
        end
        else if (fb_sum[74:FB_W+1] != '0)
        begin
            fb_eff = '1;
        end
        else
        begin
            fb_eff = fb_sum[FB_W:0];
        end
    end

    // ==========================================
    // Ratio of output to crystal, recomputed continuously
    vdc_udiv u_div
    (
        .clock(CLOCK),
        .rst_b(RST_B),
        .start(div_start),
        .num({20'h00000, fb_eff}),
        .den({48'h0, n_total}),
        .busy(div_busy),
        .done(div_done),
        .quo(div_quo)
    );

    // Restart after each result
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            div_start <= 1'b0;
        end
        else
        begin
            div_start <= !div_busy && !div_start;
        end
    end

    // Feedback over total divide, limited to half the crystal rate
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            OUTPUT_RATIO <= '0;
        end
        else if (div_done)
        begin
            if (div_quo > {32'h0, RATIO_MAX})
            begin
                OUTPUT_RATIO <= RATIO_MAX;
            end
            else
            begin
                OUTPUT_RATIO <= div_quo[RATIO_W-1:0];
            end
        end
    end

    // ==========================================
    // Phase accumulator, MSB gives 50 percent duty clock
    assign next_phase = phase + OUTPUT_RATIO;

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            phase <= '0;
            OUTPUT_CLOCK <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            OUTPUT_CLOCK <= next_phase[RATIO_W-1];
        end
    end

endmodule : vdc_device

/* File: core/vdc_host.sv */
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
// ==========================================
// Host end: Wishbone registers, checks, serial loader
module vdc_host
    import vdc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    vdc_link_if.host LINK
);
    typedef enum logic [2:0] {H_IDLE, H_FRAME, H_SHIFT, H_GAP, H_CAL, H_WAIT} vdc_hstate_e;
    vdc_hstate_e state;
    logic [FB_FRAC_W-1:0] fb_frac;
    logic [FB_INT_W-1:0] fb_int;
    logic [HS_W-1:0] hs;
    logic [LS_W-1:0] ls;
    logic [GAIN_W-1:0] gain;
    logic [15:0] cal;
    logic [4:0] pre;
    logic busy;
    logic error;
    logic [FB_W-1:0] fb;
    logic [79:0] vco_x;
    logic [N_W-1:0] n_total;
    logic bad;
    logic wr;
    logic go;
    logic [7:0] idx;
    logic [15:0] shreg;
    logic [3:0] bitn;
    logic div_start;
    logic div_done;
    logic [DIV_W-1:0] div_num;
    logic [DIV_W-1:0] div_den;
    logic [DIV_W-1:0] div_quo;

    // ==========================================
    // Range checks on the requested setting
    assign fb = {fb_int, fb_frac};
    assign vco_x = {37'h0, fb} * {32'h0, XTAL_HZ};
    assign n_total = total_div(hs, ls);
    assign bad = fb < FB_MIN || fb > FB_MAX
        || hs < HS_MIN || hs > HS_MAX || (ls == 3'h0 && hs > HS_ODD_MAX && hs[0])
        || vco_x < {VCO_MIN_HZ, 32'h0} || vco_x >= {VCO_MAX_HZ, 32'h0}
        || vco_x < {FOUT_MIN_HZ * n_total, 32'h0} || vco_x > {FOUT_MAX_HZ * n_total, 32'h0};

    // Predivider from truncated feedback integer
    assign pre = (fb_int >= PRE_EDGE_3) ? PRE_3 : (fb_int >= PRE_EDGE_2) ? PRE_2 :
        (fb_int >= PRE_EDGE_1) ? PRE_1 : PRE_0;
    assign div_den = DIV_W'(fb * {43'h0, CAL_XTAL});
    // Scale times predivider needs 25 bits, so the product is formed at 32
    assign div_num = {{8'h00, CAL_SCALE} * {27'h0, pre}, 32'h0} + {1'b0, div_den[DIV_W-1:1]};

    // ==========================================
    // Wishbone slave, registered ack
    assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
    assign go = wr && WB_ADR_I == HR_CTRL && WB_SEL_I[0] && WB_DAT_I[0] && !busy;

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end
        else
        begin
            WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
            if (WB_CYC_I && WB_STB_I && !WB_ACK_O)
            begin
                case (WB_ADR_I)
                    HR_FB_FRAC: WB_DAT_O <= fb_frac;
                    HR_FB_INT: WB_DAT_O <= {21'h0, fb_int};
                    HR_HS: WB_DAT_O <= {21'h0, hs};
                    HR_LS: WB_DAT_O <= {29'h0, ls};
                    HR_GAIN: WB_DAT_O <= {16'h0, gain};
                    HR_STATUS: WB_DAT_O <= {30'h0, error, busy};
                    HR_CAL: WB_DAT_O <= {11'h0, pre, cal};
                    default: WB_DAT_O <= '0;
                endcase
            end
        end
    end

    // Byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Setting registers, frozen while loading
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            fb_frac <= FB_RESET[FB_FRAC_W-1:0];
            fb_int <= FB_RESET[FB_W-1:FB_FRAC_W];
            hs <= HS_RESET;
            ls <= LS_RESET;
            gain <= GAIN_RESET;
        end
        else if (wr && !busy)
        begin
            case (WB_ADR_I)
                HR_FB_FRAC: fb_frac <= merge(fb_frac, WB_DAT_I, WB_SEL_I);
                HR_FB_INT: fb_int <= FB_INT_W'(merge({21'h0, fb_int}, WB_DAT_I, WB_SEL_I));
                HR_HS: hs <= HS_W'(merge({21'h0, hs}, WB_DAT_I, WB_SEL_I));
                HR_LS: ls <= LS_W'(merge({29'h0, ls}, WB_DAT_I, WB_SEL_I));
                HR_GAIN: gain <= GAIN_W'(merge({16'h0, gain}, WB_DAT_I, WB_SEL_I));
                default: ;
            endcase
        end
    end

    // Device byte for link address
    function automatic logic [7:0] dev_byte(input logic [7:0] a);
        case (a)
            DEV_HS_LO: return hs[7:0];
            DEV_HS_HI: return {5'h00, hs[10:8]};
            DEV_LS: return {5'h00, ls};
            DEV_GAIN_LO: return gain[7:0];
            DEV_GAIN_HI: return gain[15:8];
            default: return 8'((fb >> (a * 8)) & 43'h0FF);
        endcase
    endfunction : dev_byte

    // ==========================================
    // Loader sequence and calibration
    vdc_udiv u_cal
    (
        .clock(CLOCK),
        .rst_b(RST_B),
        .start(div_start),
        .num(div_num),
        .den(div_den),
        .busy(),
        .done(div_done),
        .quo(div_quo)
    );

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state <= H_IDLE;
            busy <= 1'b0;
            error <= 1'b0;
            cal <= '0;
            idx <= '0;
            shreg <= '0;
            bitn <= '0;
            div_start <= 1'b0;
            LINK.ser_frame <= 1'b0;
            LINK.ser_valid <= 1'b0;
            LINK.ser_bit <= 1'b0;
        end
        else
        begin
            div_start <= 1'b0;
            case (state)
                H_IDLE:
                begin
                    if (go)
                    begin
                        error <= bad; // Refused setting never sent
                        busy <= !bad;
                        LINK.ser_frame <= !bad;
                        idx <= DEV_FB_0;
                        state <= bad ? H_IDLE : H_FRAME;
                    end
                end
                H_FRAME:
                begin
                    shreg <= {idx, dev_byte(idx)};
                    bitn <= '0;
                    state <= H_SHIFT;
                end
                H_SHIFT:
                begin
                    LINK.ser_valid <= 1'b1;
                    LINK.ser_bit <= shreg[15];
                    shreg <= {shreg[14:0], 1'b0};
                    bitn <= bitn + 4'h1;
                    if (bitn == 4'hF)
                    begin
                        state <= H_GAP;
                    end
                end
                H_GAP:
                begin
                    LINK.ser_valid <= 1'b0;
                    LINK.ser_frame <= 1'b0;
                    if (!LINK.ser_frame)
                    begin
                        idx <= idx + 8'h01;
                        LINK.ser_frame <= idx != DEV_LAST;
                        state <= (idx == DEV_LAST) ? H_CAL : H_FRAME;
                    end
                end
                H_CAL:
                begin
                    div_start <= 1'b1;
                    state <= H_WAIT;
                end
                H_WAIT:
                begin
                    if (div_done)
                    begin
                        cal <= div_quo[15:0];
                        busy <= 1'b0;
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

endmodule : vdc_host

/* File: bench/vdc_link_sva.sv */
`timescale 1ns/10ps
// ==========================================
// Link framing checks
module vdc_link_sva
    import vdc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic ser_frame,
    input wire logic ser_valid,
    input wire logic ser_bit
);
    logic [4:0] nbits;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    // Bits seen in the current frame
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            nbits <= 5'h00;
        else if (!ser_frame)
            nbits <= 5'h00;
        else if (ser_valid)
            nbits <= nbits + 5'h01;
    end

    property p_valid_in_frame; ser_valid |-> ser_frame; endproperty
    a_valid_in_frame: assert property (p_valid_in_frame) else $error("valid outside frame");
    property p_frame_lead; $rose(ser_frame) |-> !ser_valid ##1 !ser_valid ##1 ser_valid; endproperty
    a_frame_lead: assert property (p_frame_lead) else $error("no lead cycle");
    property p_valid_run; $rose(ser_valid) |-> ser_valid[*8] ##1 ser_valid[*8] ##1 !ser_valid; endproperty
    a_valid_run: assert property (p_valid_run) else $error("valid run not 16");
    property p_frame_len; $rose(ser_frame) |-> ser_frame[*8] ##1 ser_frame[*8] ##1 ser_frame[*2] ##1 !ser_frame;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not 18 cycles");
    property p_end_together; $fell(ser_valid) |-> $fell(ser_frame); endproperty
    a_end_together: assert property (p_end_together) else $error("frame and valid apart");
    property p_bit_count; $fell(ser_frame) |-> nbits == FRAME_BITS; endproperty
    a_bit_count: assert property (p_bit_count) else $error("frame bit count");
    property p_frame_max; ser_frame[*8] ##1 ser_frame[*8] ##1 ser_frame[*2] |=> !ser_frame; endproperty
    a_frame_max: assert property (p_frame_max) else $error("frame too long");
    property p_valid_start; $rose(ser_valid) |-> $past(ser_frame); endproperty
    a_valid_start: assert property (p_valid_start) else $error("valid before frame");
endmodule : vdc_link_sva

/* File: bench/vcxo_divider_chain_config_tb_top.sv */
`timescale 1ns/10ps
// ==========================================
// Bench: host and device joined over the link
module vcxo_divider_chain_config_tb_top;
    import vdc_pkg::*;
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] st;
    logic ack;
    logic [CV_W-1:0] cv = 12'h800;
    logic [RATIO_W-1:0] ratio;
    logic [31:0] base;
    logic oclk;
    int num_errors = 0;
    int n_checks = 0;

    vdc_link_if vdc_link_if_inst ();
    vdc_host vdc_host_inst (.CLOCK(CLOCK), .RST_B(RST_B), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(4'hF), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .LINK(vdc_link_if_inst.host));
    vdc_device vdc_device_inst (.CLOCK(CLOCK), .RST_B(RST_B), .LINK(vdc_link_if_inst.device),
        .CONTROL_VOLTAGE_PIN(cv), .OUTPUT_CLOCK(oclk), .OUTPUT_RATIO(ratio));
    vdc_link_sva vdc_link_sva_inst (.CLOCK(CLOCK), .RST_B(RST_B), .ser_frame(vdc_link_if_inst.ser_frame),
        .ser_valid(vdc_link_if_inst.ser_valid), .ser_bit(vdc_link_if_inst.ser_bit));

    // Clock
    always #5 CLOCK = ~CLOCK;

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check

    // One classic Wishbone cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge CLOCK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge CLOCK); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // Program dividers, start a load, wait until idle
    task automatic cfg(input logic [10:0] fi, input logic [10:0] h, input logic [2:0] e);
        wb(1'b1, HR_FB_FRAC, 32'h0, st);
        wb(1'b1, HR_FB_INT, {21'h0, fi}, st);
        wb(1'b1, HR_HS, {21'h0, h}, st);
        wb(1'b1, HR_LS, {29'h0, e}, st);
        wb(1'b1, HR_CTRL, 32'h1, st);
        st = 32'h1;
        while (st[0]) wb(1'b0, HR_STATUS, 32'h0, st);
    endtask : cfg

    // Ratio expected for feedback 71.0
    function automatic logic [31:0] want_ratio(input logic [10:0] h, input logic [2:0] e);
        logic [63:0] q;
        q = 64'h47_0000_0000 / ({53'h0, h} << ((e > 3'h5) ? 3'h5 : e));
        return (q > 64'h8000_0000) ? 32'h8000_0000 : q[31:0];
    endfunction : want_ratio

    task automatic see(input logic [31:0] x);
        for (int i = 0; i < 400 && ratio !== x; i++) @(posedge CLOCK);
        check(ratio, x);
    endtask : see

    task automatic t_reset();
        wb(1'b0, HR_FB_INT, 32'h0, st);
        check(st, 32'h47);
        wb(1'b0, HR_HS, 32'h0, st);
        check(st, 32'h46);
        wb(1'b0, HR_LS, 32'h0, st);
        check(st, 32'h0);
        wb(1'b0, 8'h40, 32'h0, st);
        check(st, 32'h0);
        see(32'h8000_0000);
        base = {31'h0, oclk};
        @(posedge CLOCK);
        check({31'h0, oclk ^ base[0]}, 32'h1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_refuse();
        cfg(11'h047, 11'h045, 3'h0);
        check({31'h0, st[1]}, 32'h1);
        cfg(11'h047, 11'h003, 3'h1);
        check({31'h0, st[1]}, 32'h1);
        cfg(11'h03B, 11'h046, 3'h0);
        check({31'h0, st[1]}, 32'h1);
        cfg(11'h056, 11'h046, 3'h0);
        check({31'h0, st[1]}, 32'h1);
        cfg(11'h050, 11'h004, 3'h0);
        check({31'h0, st[1]}, 32'h1);
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_ratio();
        logic [10:0] hs_t [4] = '{11'h0C8, 11'h0C8, 11'h0C9, 11'h7FE};
        logic [2:0] ls_t [4] = '{3'h5, 3'h7, 3'h1, 3'h0};
        for (int i = 0; i < 4; i++)
        begin
            cfg(11'h047, hs_t[i], ls_t[i]);
            check({31'h0, st[1]}, 32'h0);
            see(want_ratio(hs_t[i], ls_t[i]));
        end
        // Feedback 71: predivider 16, calibration 121
        wb(1'b0, HR_CAL, 32'h0, st);
        check(st, 32'h0010_0079);
        $display("test ratio done");
    endtask : t_ratio

    task automatic t_pull();
        base = ratio;
        wb(1'b1, HR_GAIN, 32'hFFFF, st);
        cfg(11'h047, 11'h7FE, 3'h0);
        cv <= 12'h900;
        repeat (300) @(posedge CLOCK);
        check((ratio > base) ? 32'h1 : 32'h0, 32'h1);
        cv <= 12'h700;
        repeat (300) @(posedge CLOCK);
        check((ratio < base) ? 32'h1 : 32'h0, 32'h1);
        $display("test pull done");
    endtask : t_pull

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // Watchdog
    initial
    begin
        repeat (40000) @(posedge CLOCK);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        repeat (5) @(posedge CLOCK);
        RST_B <= 1'b1;
        t_reset();
        t_refuse();
        t_ratio();
        t_pull();
        tally_and_finish();
    end
endmodule : vcxo_divider_chain_config_tb_top
